// file: sensor_video_output_control_test.sv
// self-checking bench for the sensor video output control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %h got %h", nm, e, g); end end
module sensor_video_output_control_test;
  import svoc_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       oe_pin;
  svoc_vid_t  vid;
  svoc_pins_t pins;
  logic       clkgen_en;
  logic       legacy;
  logic [3:0] current_gain_dac;
  logic [5:0] capacitor_gain_dac;
  logic [7:0] cap;
  logic [7:0] eb;
  logic [7:0] ev;
  logic [7:0] exp_q[$];
  logic       rd_d1 = 1'b0;
  logic       rd_d2 = 1'b0;
  logic       pn, s, q, d;
  int         miscompares;
  int         n_compared;
  int         cnt;

  svoc_top i_svoc_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .out_disable_pin_i(oe_pin), .vid_i(vid),
    .pins_o(pins), .clkgen_en_o(clkgen_en), .legacy_layout_o(legacy),
    .current_gain_dac_o(current_gain_dac), .capacitor_gain_dac_o(capacitor_gain_dac));

  svoc_capture i_svoc_capture (.pins_i(pins), .cap_o(cap));

  // ----------------------------------------
  // clock, tasks and read monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  // strobe drops for one cycle so it is never set twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
  endtask : rd_reg

  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    rd_d1 <= rd;
    rd_d2 <= rd_d1;
  end

  // read data is valid one cycle after the read edge
  always @(negedge clk) begin
    if (rd_d2 === 1'b1) begin
      ev = exp_q.pop_front();
      `CHK("reg_rdata_o", ev, rdata)
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    oe_pin = 1'b0;
    vid = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(99));
    repeat (16) @(posedge clk);
    #2;
    rst_n = 1'b1;
    step(2);
    `CHK("legacy_layout_o", 1'b1, legacy)
    `CHK("frame_oe", 1'b1, pins.frame_oe)
    `CHK("data_oe", MASK_5W, pins.data_oe)
    rd_reg(ADDR_RDF, RST_RDF);
    rd_reg(ADDR_OPF, RST_OPF);
    rd_reg(ADDR_MDS, RST_MDS);
    rd_reg(ADDR_GAIN, RST_GAIN);
    rd_reg(8'h30, 8'h00);
    for (int w = 0; w < 4; w++) begin
      wr_reg(ADDR_OPF, {6'h06, w[1:0]});
      step(3);
      `CHK("data_oe width", (w == 0) ? MASK_5W : (w == 1) ? MASK_4W : MASK_8W, pins.data_oe)
    end
    for (int i = 0; i < 8; i++) begin
      {pn, s, q, d} = 4'($urandom);
      wr_reg(ADDR_OPF, {2'b00, d, 5'h18});
      wr_reg(ADDR_RDF, {1'b0, q, s, 5'h01});
      oe_pin = pn;
      step(5);
      `CHK("frame_oe", ~(pn | s), pins.frame_oe)
      `CHK("line_oe", ~(pn | s), pins.line_oe)
      `CHK("qck_oe", ~(pn | q), pins.qck_oe)
      `CHK("data_oe", (pn | d) ? 8'h00 : MASK_5W, pins.data_oe)
      rd_reg(ADDR_RDF, {1'b0, q, s, 5'h01});
    end
    oe_pin = 1'b0;
    wr_reg(ADDR_OPF, RST_OPF);
    wr_reg(ADDR_RDF, RST_RDF);
    step(4);
    // retimed disables wait for the field boundary, readback does not
    wr_reg(ADDR_OPF, 8'h58);
    wr_reg(ADDR_OPF, 8'h78);
    wr_reg(ADDR_RDF, 8'h61);
    rd_reg(ADDR_RDF, 8'h61);
    rd_reg(ADDR_OPF, 8'h78);
    step(4);
    `CHK("data_oe held", MASK_5W, pins.data_oe)
    `CHK("qck_oe held", 1'b1, pins.qck_oe)
    vid.field_bnd = 1'b1;
    step(1);
    vid.field_bnd = 1'b0;
    step(3);
    `CHK("data_oe retimed", 8'h00, pins.data_oe)
    `CHK("frame_oe retimed", 1'b0, pins.frame_oe)
    wr_reg(ADDR_OPF, RST_OPF);
    wr_reg(ADDR_RDF, RST_RDF);
    step(4);
    `CHK("data_oe immediate", MASK_5W, pins.data_oe)
    vid.data = 8'h55;
    for (int k = 0; k < 2; k++) begin
      vid.sav = (k == 0);
      vid.eav = (k == 1);
      step(1);
      vid.sav = 1'b0;
      vid.eav = 1'b0;
      step(1);
      for (int j = 0; j < 4; j++) begin
        eb = (j == 3) ? (k ? CODE_EAV : CODE_SAV) : ((j == 0) ? CODE_PRE : CODE_ZERO);
        `CHK("code byte", eb, pins.data)
        step(1);
      end
    end
    wr_reg(ADDR_OPF, 8'h1c);
    vid.line = 1'b1;
    vid.frame = 1'b1;
    vid.qualifying_pixel_clock = 1'b1;
    vid.sav = 1'b1;
    step(1);
    vid.sav = 1'b0;
    step(2);
    `CHK("raw data", 8'h55, pins.data)
    `CHK("frame off", 1'b0, pins.frame)
    `CHK("line kept", 1'b1, pins.line)
    `CHK("qck stopped", 1'b0, pins.qualifying_pixel_clock)
    vid.qck_free = 1'b1;
    step(2);
    `CHK("qck free", 1'b1, pins.qualifying_pixel_clock)
    wr_reg(ADDR_OPF, 8'h1a);
    vid.data = 8'hb3;
    for (int c = 0; c < 3; c++) begin
      vid.qualifying_pixel_clock = 1'b1;
      step(4);
      vid.qualifying_pixel_clock = 1'b0;
      step(4);
    end
    `CHK("frame pin bit5", 1'b1, pins.frame)
    `CHK("line pin bit6", 1'b0, pins.line)
    vid.data = 8'h93;
    step(3);
    `CHK("bit5 waits for edge", 1'b1, pins.frame)
    `CHK("captured byte", 8'hb3, cap)
    for (int m = 0; m < 2; m++) begin
      wr_reg(ADDR_RDF, m ? 8'h81 : 8'h01);
      step(3);
      cnt = 0;
      repeat (30) begin
        cnt += (clkgen_en === 1'b1);
        step(1);
      end
      `CHK("clkgen enables", m ? 20 : 30, cnt)
    end
    wr_reg(ADDR_GAIN, 8'ha5);
    rd_reg(ADDR_GAIN, 8'ha5);
    step(3);
    `CHK("current dac", 4'h5, current_gain_dac)
    `CHK("capacitor dac", 6'h2a, capacitor_gain_dac)
    wr_reg(ADDR_MDS, 8'h03);
    wr_reg(ADDR_GAIN, 8'h37);
    rd_reg(ADDR_GAIN, 8'ha7);
    step(3);
    `CHK("retro current dac", 4'h8, current_gain_dac)
    `CHK("retro capacitor dac", 6'h2b, capacitor_gain_dac)
    wr_reg(ADDR_MDS, 8'h04);
    step(3);
    `CHK("legacy cleared", 1'b0, legacy)
    // log ramp: four pixel steps after line start drop the capacitor value by two
    vid.sav = 1'b1;
    step(1);
    vid.sav = 1'b0;
    vid.active = 1'b1;
    step(4);
    vid.active = 1'b0;
    step(2);
    `CHK("log ramp dac", 6'h28, capacitor_gain_dac)
    step(4);
    `CHK("reads answered", 0, exp_q.size())
    finish_test();
  end
endmodule : sensor_video_output_control_test

// file: svoc_capture.sv
// capture-side model of the video coprocessor latching the parallel port
`timescale 1ns/100ps
module svoc_capture
  import svoc_pkg::*;
#(
  parameter realtime QCK_DLY = 50.0
)(
  // pads from the sensor
  input  wire svoc_pins_t pins_i,
  // last captured byte
  output logic [7:0]      cap_o
);
  // delayed sampling edge
  // the late pair on the strobe pins settles only after the falling edge
  always @(negedge pins_i.qualifying_pixel_clock) begin
    #(QCK_DLY);
    cap_o = {pins_i.data[7], pins_i.line, pins_i.frame, pins_i.data[4:0]};
  end
endmodule : svoc_capture

// file: svoc_gain.sv
// gain mapping onto current and capacitor dac fields with optional log ramp
`timescale 1ns/100ps
module svoc_gain
  import svoc_pkg::*;
#(
  parameter int POS_W = 8
)(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic [7:0]  gain_i,
  input  wire logic        retro_i,
  input  wire logic        log_en_i,
  input  wire logic        line_start_i,
  input  wire logic        pix_step_i,
  // towards the analog column block
  output logic [3:0]       current_gain_dac_o,
  output logic [5:0]       capacitor_gain_dac_o
);

  if (POS_W < 4 || POS_W > 16) begin : g_chk
    $error("svoc_gain: POS_W must be 4..16");
  end

  // floor of log2, zero for zero
  function automatic logic [5:0] flog2(input logic [POS_W-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < POS_W; i++) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : flog2

  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;
  logic [3:0]       next_current_gain_dac;
  logic [5:0]       next_capacitor_gain_dac;
  logic [5:0]       base;
  logic [5:0]       drop;

  always_comb begin
    next_pos = pos;
    if (line_start_i) begin
      next_pos = '0;
    end else if (pix_step_i && !(&pos)) begin
      next_pos = pos + 1'b1;
    end
    // split into 4-bit and 6-bit fields
    base = {gain_i[7:4], gain_i[7:6]};
    drop = flog2(pos);
    // constant value unless the log ramp is chosen
    next_capacitor_gain_dac = base;
    if (log_en_i) begin
      next_capacitor_gain_dac = (drop > base) ? 6'h00 : base - drop;
    end
    // inverted nibble and forced low pair
    next_current_gain_dac = retro_i ? ~gain_i[3:0] : gain_i[3:0];
    if (retro_i) begin
      next_capacitor_gain_dac[1:0] = CAPACITOR_GAIN_DAC_RETRO_LO;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pos                  <= '0;
      current_gain_dac_o   <= 4'h0;
      capacitor_gain_dac_o <= 6'h00;
    end else begin
      pos                  <= next_pos;
      current_gain_dac_o   <= next_current_gain_dac;
      capacitor_gain_dac_o <= next_capacitor_gain_dac;
    end
  end

  property p_retro_map;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    retro_i |=> current_gain_dac_o == ~$past(gain_i[3:0]) && capacitor_gain_dac_o[1:0] == 2'h3;
  endproperty
  a_retro_map: assert property (p_retro_map) else $error("retro gain mapping wrong");

  property p_flat_capacitor_gain_dac;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !log_en_i && !retro_i |=> capacitor_gain_dac_o == {$past(gain_i[7:4]), $past(gain_i[7:6])};
  endproperty
  a_flat_capacitor_gain_dac: assert property (p_flat_capacitor_gain_dac) else $error("capacitor dac not constant");

endmodule : svoc_gain

// file: svoc_pkg.sv
// shared constants and carriers for the sensor video output control block
package svoc_pkg;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RDF  = 8'h16;
  localparam logic [7:0] ADDR_OPF  = 8'h17;
  localparam logic [7:0] ADDR_MDS  = 8'h18;
  localparam logic [7:0] ADDR_GAIN = 8'h24;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_RDF  = 8'h01;
  localparam logic [7:0] RST_OPF  = 8'h18;
  localparam logic [7:0] RST_MDS  = 8'h01;
  localparam logic [7:0] RST_GAIN = 8'hf0;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int RDF_STROBE_TS = 5;
  localparam int RDF_QCK_TS    = 6;
  localparam int RDF_PREDIV    = 7;
  localparam int OPF_WIDTH_LO  = 0;
  localparam int OPF_WIDTH_HI  = 1;
  localparam int OPF_PASSTHRU  = 2;
  localparam int OPF_DATA_TS   = 5;
  localparam int OPF_RETIME    = 6;
  localparam int MDS_LEGACY    = 0;
  localparam int MDS_RETRO     = 1;
  localparam int MDS_LOGRAMP   = 2;
  localparam int PIN_FRAME_BIT = 5;
  localparam int PIN_LINE_BIT  = 6;

  // ------------------------------------------------------------
  // width selections and pin masks
  // ------------------------------------------------------------
  localparam logic [1:0] WIDTH_5W    = 2'h0;
  localparam logic [1:0] WIDTH_4W    = 2'h1;
  localparam logic [7:0] MASK_5W     = 8'h1f;
  localparam logic [7:0] MASK_4W     = 8'h0f;
  localparam logic [7:0] MASK_8W     = 8'h9f;

  // ------------------------------------------------------------
  // embedded code bytes and gain constants
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_PRE    = 8'hff;
  localparam logic [7:0] CODE_ZERO   = 8'h00;
  localparam logic [7:0] CODE_SAV    = 8'h80;
  localparam logic [7:0] CODE_EAV    = 8'h9d;
  localparam logic [1:0] CAPACITOR_GAIN_DAC_RETRO_LO = 2'h3;

  // divide by 1.5: two clock-generator enables every three cycles
  localparam logic [1:0] PREDIV_LAST = 2'h2;

  typedef enum logic [4:0] {
    C_IDLE = 5'b00001,
    C_PRE  = 5'b00010,
    C_Z1   = 5'b00100,
    C_Z2   = 5'b01000,
    C_ID   = 5'b10000
  } svoc_code_t;

  // video timing inputs from the sensor core, same clock
  typedef struct packed {
    logic [7:0] data;
    logic       active;
    logic       sav;
    logic       eav;
    logic       frame;
    logic       line;
    logic       qualifying_pixel_clock;
    logic       qck_free;
    logic       field_bnd;
  } svoc_vid_t;

  // pad-side outputs with their enables
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe;
    logic       frame;
    logic       frame_oe;
    logic       line;
    logic       line_oe;
    logic       qualifying_pixel_clock;
    logic       qck_oe;
  } svoc_pins_t;

endpackage : svoc_pkg

// file: svoc_prediv.sv
// input clock pre-divider producing clock generator enables
`timescale 1ns/100ps
module svoc_prediv
  import svoc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic div_en_i,
  // enable towards the clock generator
  output logic      clkgen_en_o
);

  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       next_en;

  always_comb begin
    next_cnt = 2'h0;
    next_en  = 1'b1;
    if (div_en_i) begin
      next_cnt = (cnt == PREDIV_LAST) ? 2'h0 : cnt + 2'h1;
      next_en  = (cnt != PREDIV_LAST);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt         <= 2'h0;
      clkgen_en_o <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      clkgen_en_o <= next_en;
    end
  end

  property p_prediv_gap;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    div_en_i [*4] |-> !(clkgen_en_o && $past(clkgen_en_o) && $past(clkgen_en_o, 2));
  endproperty
  a_prediv_gap: assert property (p_prediv_gap) else $error("pre-divider gave three enables in a row");

  property p_prediv_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !div_en_i |=> clkgen_en_o;
  endproperty
  a_prediv_off: assert property (p_prediv_off) else $error("undivided clock lost an enable");

endmodule : svoc_prediv

// file: svoc_top.sv
// sensor video output control: registers, output width, codes, tri-state
`timescale 1ns/100ps

module svoc_top
  import svoc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // external output-disable pin
  input  wire logic        out_disable_pin_i,
  // video timing from the sensor core
  input  svoc_vid_t        vid_i,
  // pads
  output svoc_pins_t       pins_o,
  // towards clock generator and analog column block
  output logic             clkgen_en_o,
  output logic             legacy_layout_o,
  output logic [3:0]       current_gain_dac_o,
  output logic [5:0]       capacitor_gain_dac_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] width_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = MASK_8W;
    if (sel == WIDTH_5W) begin
      m = MASK_5W;
    end else if (sel == WIDTH_4W) begin
      m = MASK_4W;
    end
    return m;
  endfunction : width_mask

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] rdf;
  logic [7:0] opf;
  logic [7:0] mds;
  logic [7:0] gain;
  logic [7:0] next_rdf;
  logic [7:0] next_opf;
  logic [7:0] next_mds;
  logic [7:0] next_gain;
  logic [7:0] next_rdata;

  always_comb begin
    next_rdf   = rdf;
    next_opf   = opf;
    next_mds   = mds;
    next_gain  = gain;
    next_rdata = reg_rdata_o;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_RDF: begin
          next_rdf = reg_wdata_i;
        end
        ADDR_OPF: begin
          next_opf = reg_wdata_i;
        end
        ADDR_MDS: begin
          next_mds = reg_wdata_i;
        end
        // upper nibble held in retro mode
        ADDR_GAIN: begin
          next_gain = mds[MDS_RETRO] ? {gain[7:4], reg_wdata_i[3:0]} : reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
    // readback shows the stored bit, not the retimed one
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_RDF: begin
          next_rdata = rdf;
        end
        ADDR_OPF: begin
          next_rdata = opf;
        end
        ADDR_MDS: begin
          next_rdata = mds;
        end
        ADDR_GAIN: begin
          next_rdata = gain;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdf         <= RST_RDF;
      opf         <= RST_OPF;
      mds         <= RST_MDS;
      gain        <= RST_GAIN;
      reg_rdata_o <= 8'h00;
    end else begin
      rdf         <= next_rdf;
      opf         <= next_opf;
      mds         <= next_mds;
      gain        <= next_gain;
      reg_rdata_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // pin synchroniser and effective tri-state bits
  // ------------------------------------------------------------
  logic oeb_meta;
  logic oeb_sync;
  logic ts_strobe;
  logic ts_qck;
  logic ts_data;
  logic next_ts_strobe;
  logic next_ts_qck;
  logic next_ts_data;

  always_comb begin
    // follow the register bits straight away unless retiming holds them until the field boundary
    next_ts_strobe = rdf[RDF_STROBE_TS];
    next_ts_qck    = rdf[RDF_QCK_TS];
    next_ts_data   = opf[OPF_DATA_TS];
    if (opf[OPF_RETIME] && !vid_i.field_bnd) begin
      next_ts_strobe = ts_strobe;
      next_ts_qck    = ts_qck;
      next_ts_data   = ts_data;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      oeb_meta  <= 1'b0;
      oeb_sync  <= 1'b0;
      ts_strobe <= 1'b0;
      ts_qck    <= 1'b0;
      ts_data   <= 1'b0;
    end else begin
      oeb_meta  <= out_disable_pin_i;
      oeb_sync  <= oeb_meta;
      ts_strobe <= next_ts_strobe;
      ts_qck    <= next_ts_qck;
      ts_data   <= next_ts_data;
    end
  end

  // ------------------------------------------------------------
  // embedded code insertion
  // ------------------------------------------------------------
  svoc_code_t state;
  svoc_code_t next_state;
  logic [7:0] code_id;
  logic [7:0] next_code_id;
  logic [7:0] sym;
  logic       passthru;

  assign passthru = opf[OPF_PASSTHRU];

  // four-byte marker ahead of and after active video
  always_comb begin
    next_state   = state;
    next_code_id = code_id;
    sym          = vid_i.data;
    case (state)
      C_IDLE: begin
        if (!passthru && (vid_i.sav || vid_i.eav)) begin
          next_state   = C_PRE;
          next_code_id = vid_i.sav ? CODE_SAV : CODE_EAV;
        end
      end
      C_PRE: begin
        sym        = CODE_PRE;
        next_state = C_Z1;
      end
      C_Z1: begin
        sym        = CODE_ZERO;
        next_state = C_Z2;
      end
      C_Z2: begin
        sym        = CODE_ZERO;
        next_state = C_ID;
      end
      C_ID: begin
        sym        = code_id;
        next_state = C_IDLE;
      end
      default: begin
        next_state = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state   <= C_IDLE;
      code_id <= 8'h00;
    end else begin
      state   <= next_state;
      code_id <= next_code_id;
    end
  end

  // ------------------------------------------------------------
  // pad drive
  // ------------------------------------------------------------
  logic       qck_d;
  logic       qck_fall;
  logic [1:0] late;
  logic [1:0] next_late;
  logic       wide;
  svoc_pins_t next_pins;

  assign wide     = opf[OPF_WIDTH_HI];
  assign qck_fall = qck_d && !vid_i.qualifying_pixel_clock;

  always_comb begin
    // late pair follows the sampling edge
    next_late = late;
    if (qck_fall) begin
      next_late = {sym[PIN_LINE_BIT], sym[PIN_FRAME_BIT]};
    end
    next_pins      = '0;
    next_pins.data = sym;
    // pins beyond the chosen width stay released
    next_pins.data_oe = (oeb_sync || ts_data) ? 8'h00 : width_mask(opf[OPF_WIDTH_HI:OPF_WIDTH_LO]);
    // frame strobe dropped with the codes; line strobe untouched
    next_pins.frame = passthru ? 1'b0 : vid_i.frame;
    next_pins.line  = vid_i.line;
    // strobe pins carry data bits 5 and 6
    if (wide) begin
      next_pins.frame = late[0];
      next_pins.line  = late[1];
    end
    // clock runs in pass-through only when free-running
    next_pins.qualifying_pixel_clock = (passthru && !vid_i.qck_free) ? 1'b0 : vid_i.qualifying_pixel_clock;
    next_pins.frame_oe = !(oeb_sync || ts_strobe);
    next_pins.line_oe  = !(oeb_sync || ts_strobe);
    next_pins.qck_oe = !(oeb_sync || ts_qck);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      qck_d           <= 1'b0;
      late            <= 2'h0;
      pins_o          <= '0;
      legacy_layout_o <= 1'b1;
    end else begin
      qck_d           <= vid_i.qualifying_pixel_clock;
      late            <= next_late;
      pins_o          <= next_pins;
      legacy_layout_o <= mds[MDS_LEGACY];
    end
  end

  // ------------------------------------------------------------
  // clock pre-divider and gain mapping
  // ------------------------------------------------------------
  svoc_prediv u_prediv (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .div_en_i    (rdf[RDF_PREDIV]),
    .clkgen_en_o (clkgen_en_o)
  );

  svoc_gain #(.POS_W(8)) u_gain (
    .core_clk_i           (core_clk_i),
    .rst_n_i              (rst_n_i),
    .gain_i               (gain),
    .retro_i              (mds[MDS_RETRO]),
    .log_en_i             (mds[MDS_LOGRAMP]),
    .line_start_i         (vid_i.sav),
    .pix_step_i           (vid_i.active),
    .current_gain_dac_o   (current_gain_dac_o),
    .capacitor_gain_dac_o (capacitor_gain_dac_o)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_rdf_readback;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == ADDR_RDF) ##1 !reg_wr_i ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_RDF)
      |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_rdf_readback: assert property (p_rdf_readback) else $error("format readback not immediate");

  property p_strobe_off;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == ADDR_RDF && reg_wdata_i[5] && !opf[OPF_RETIME]) ##1 (!reg_wr_i) [*2]
      |=> !pins_o.frame_oe && !pins_o.line_oe;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobes still enabled after tri-state write");

  property p_pin_disable;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    oeb_sync |=> !pins_o.qck_oe && !pins_o.frame_oe;
  endproperty
  a_pin_disable: assert property (p_pin_disable) else $error("disable pin did not release clock");

  property p_data_disable;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (oeb_sync || ts_data) |=> pins_o.data_oe == 8'h00;
  endproperty
  a_data_disable: assert property (p_data_disable) else $error("data pins driven while disabled");

  property p_four_wire;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (opf[1:0] == 2'h1 && !oeb_sync && !ts_data) |=> pins_o.data_oe == 8'h0f;
  endproperty
  a_four_wire: assert property (p_four_wire) else $error("four-wire enable mask wrong");

  property p_code_seq;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state == C_IDLE && !passthru && vid_i.sav)
      |-> ##2 pins_o.data == 8'hff ##1 pins_o.data == 8'h00 ##1 pins_o.data == 8'h00 ##1 pins_o.data == 8'h80;
  endproperty
  a_code_seq: assert property (p_code_seq) else $error("start code sequence wrong");

  property p_passthru_frame;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (passthru && !wide) |=> !pins_o.frame;
  endproperty
  a_passthru_frame: assert property (p_passthru_frame) else $error("frame strobe active in pass-through");

  property p_late_bits;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wide && qck_fall) ##1 wide |=> pins_o.frame == $past(sym[5], 2) && pins_o.line == $past(sym[6], 2);
  endproperty
  a_late_bits: assert property (p_late_bits) else $error("strobe-pin data not taken at falling edge");

  property p_retime_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (opf[OPF_RETIME] && !vid_i.field_bnd && rdf[RDF_QCK_TS] != ts_qck) |=> ts_qck == $past(ts_qck);
  endproperty
  a_retime_hold: assert property (p_retime_hold) else $error("tri-state changed before field boundary");

  c_code_seq: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) state == C_ID);
  c_late_bits: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) wide && qck_fall);
  c_retime: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) opf[OPF_RETIME] && vid_i.field_bnd);

endmodule : svoc_top
